//--- rcr_top.sv
`timescale 1ns/1ps
module rcr_top #(
    parameter logic [31:0] SETTLE_RESET = rcr_pkg::RCR_SETTLE_CYC
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RSTN,
    // AXI4-Lite write address
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    // AXI4-Lite write data
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read address
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    // AXI4-Lite read data
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Mains and breaker pins, one bit or one decoupling group per instance; transformer fault shared by both
    input wire logic [1:0] BRK_CLOSED_IN,
    input wire logic [rcr_pkg::RCR_NDEC-1:0] DECOUP0_IN,
    input wire logic [rcr_pkg::RCR_NDEC-1:0] DECOUP1_IN,
    input wire logic [1:0] VOLT_OK_IN,
    input wire logic [1:0] FREQ_OK_IN,
    input wire logic [1:0] EXTERNAL_VOLTAGE_OK_IN,
    input wire logic TRANSFORMER_FAULT_IN,
    input wire logic [1:0] EXTERNAL_BLOCK_IN,
    // Results
    output logic [1:0] EVAL_OUT,
    output logic [1:0] RELEASE_OUT
);
    import rcr_pkg::*;

    localparam int unsigned NPIN = 23;

    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync1;
    logic [NPIN-1:0] sync2;
    logic [NPIN-1:0] sync3;
    logic [NPIN-1:0] pin_f;
    logic [NPIN-1:0] next_pin_f;
    logic [11:0] ctrl [2];
    logic [31:0] settle [2];
    logic [7:0] aw_addr;
    logic aw_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_got;
    logic do_write;
    logic [1:0] eval;
    logic [1:0] rel;

    // Register index of an aligned offset; 3'h7 marks unmapped
    function automatic logic [2:0] reg_sel(input logic [7:0] a);
        case (a)
            RCR_CTRL0_OFS: reg_sel = 3'h0;
            RCR_SETTLE0_OFS: reg_sel = 3'h1;
            RCR_CTRL1_OFS: reg_sel = 3'h2;
            RCR_SETTLE1_OFS: reg_sel = 3'h3;
            RCR_STATUS_OFS: reg_sel = 3'h4;
            default: reg_sel = 3'h7;
        endcase
    endfunction

    // Byte-lane merge of a write into an old value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
        input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    // Pin collection and three-stage synchroniser
    assign pin_raw = {EXTERNAL_BLOCK_IN, TRANSFORMER_FAULT_IN, EXTERNAL_VOLTAGE_OK_IN,
        FREQ_OK_IN, VOLT_OK_IN, DECOUP1_IN, DECOUP0_IN, BRK_CLOSED_IN};
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else begin
            sync1 <= pin_raw;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // A pin change counts once the second and third stage agree
    assign next_pin_f = (sync2 & ~(sync2 ^ sync3)) | (pin_f & (sync2 ^ sync3));
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            pin_f <= '0;
        end else begin
            pin_f <= next_pin_f;
        end
    end

    // Write address and data captured in either order
    assign S_AXI_AWREADY = !aw_got && !S_AXI_BVALID;
    assign S_AXI_WREADY = !w_got && !S_AXI_BVALID;
    assign do_write = aw_got && w_got && !S_AXI_BVALID;
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            aw_got <= 1'b0;
            aw_addr <= 8'h00;
            w_got <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_got <= 1'b1;
                aw_addr <= S_AXI_AWADDR;
            end else if (do_write) begin
                aw_got <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_got <= 1'b1;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
            end else if (do_write) begin
                w_got <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= RCR_RESP_OKAY;
        end else if (do_write) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= (reg_sel(aw_addr) > 3'h3) ? RCR_RESP_SLVERR : RCR_RESP_OKAY;
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // Configuration registers, one set per instance
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl[0] <= RCR_CTRL_RST;
            ctrl[1] <= RCR_CTRL_RST;
            settle[0] <= SETTLE_RESET;
            settle[1] <= SETTLE_RESET;
        end else if (do_write) begin
            case (reg_sel(aw_addr))
                3'h0: ctrl[0] <= 12'(merge({20'h0, ctrl[0]}, w_data, w_strb)); // [R14]
                3'h1: settle[0] <= merge(settle[0], w_data, w_strb);
                3'h2: ctrl[1] <= 12'(merge({20'h0, ctrl[1]}, w_data, w_strb)); // [R14]
                3'h3: settle[1] <= merge(settle[1], w_data, w_strb);
                default: ;
            endcase
        end
    end

    // Read channel
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= RCR_RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP <= RCR_RESP_OKAY;
            case (reg_sel(S_AXI_ARADDR))
                3'h0: S_AXI_RDATA <= {20'h0, ctrl[0]};
                3'h1: S_AXI_RDATA <= settle[0];
                3'h2: S_AXI_RDATA <= {20'h0, ctrl[1]};
                3'h3: S_AXI_RDATA <= settle[1];
                3'h4: S_AXI_RDATA <= {28'h0, rel, eval};
                default: begin
                    S_AXI_RDATA <= 32'h0000_0000;
                    S_AXI_RRESP <= RCR_RESP_SLVERR;
                end
            endcase
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // Two independent reconnection instances; each may be blocked by the other
    rcr_channel u_ch0 (
        .clk(MCLK),
        .rst_n(RSTN),
        .ctrl(ctrl[0]),
        .settle(settle[0]),
        .brk_closed(pin_f[0]),
        .decoup(pin_f[7:2]),
        .volt_ok(pin_f[14]),
        .freq_ok(pin_f[16]),
        .ext_volt_ok(pin_f[18]),
        .tf_fault(pin_f[20]),
        .ext_block(pin_f[21]),
        .other_eval(eval[1]),
        .eval(eval[0]),
        .release_o(rel[0])
    );
    rcr_channel u_ch1 (
        .clk(MCLK),
        .rst_n(RSTN),
        .ctrl(ctrl[1]),
        .settle(settle[1]),
        .brk_closed(pin_f[1]),
        .decoup(pin_f[13:8]),
        .volt_ok(pin_f[15]),
        .freq_ok(pin_f[17]),
        .ext_volt_ok(pin_f[19]),
        .tf_fault(pin_f[20]),
        .ext_block(pin_f[22]),
        .other_eval(eval[0]),
        .eval(eval[1]),
        .release_o(rel[1])
    );

    assign EVAL_OUT = eval;
    assign RELEASE_OUT = rel;
endmodule // rcr_top

//--- rcr_channel.sv
// Overview of operation
// R1: Breaker+decoupling mode: trigger on breaker fall with decoupling
// R2: Evaluate after breaker opens, flag shown throughout
// R3: Conditions held, delay expired: release, flag drops
// R4: Breaker+decoupling: release drops on close, decoupling, conditions
// R5: Breaker-only mode: trigger on breaker falling edge
// R6: Breaker-only: release drops on close or conditions
// R7: Decoupling-only mode: trigger on any decoupling activation
// R8: Decoupling-only: release held until decoupling or conditions
// R9: Unassigned mode: trigger whenever release conditions fail
// R10: Unassigned: release held until a condition fails
// R11: Conditions from frequency plus measured and/or external voltage
// R12: Frequency limits kept within 4 Hz of nominal
// R13: Decoupling precedes breaker fall, may drop after trigger
// R14: Two independent instances with own settings
// R15: Blocked second instance delay at least one period
// R16: Inactive when disabled, blocked, or transformer fault used
// R17: Up to 6 decoupling inputs, ORed together
// R18: Settle timer runs only while conditions hold, restarts
// R19: External block input suppresses release
// R20: Reset or block: idle, outputs low, timer cleared
// R21: Evaluating flag and release never high together
package rcr_pkg;
    localparam int unsigned RCR_CLK_MHZ = 200;
    localparam int unsigned RCR_SETTLE_US = 1000;
    localparam logic [31:0] RCR_SETTLE_CYC = 32'(RCR_SETTLE_US * RCR_CLK_MHZ);
    localparam int unsigned RCR_NDEC = 6;
    // Byte offsets
    localparam logic [7:0] RCR_CTRL0_OFS = 8'h00;
    localparam logic [7:0] RCR_SETTLE0_OFS = 8'h04;
    localparam logic [7:0] RCR_CTRL1_OFS = 8'h08;
    localparam logic [7:0] RCR_SETTLE1_OFS = 8'h0c;
    localparam logic [7:0] RCR_STATUS_OFS = 8'h10;
    // Control fields
    localparam int unsigned RCR_EN_BIT = 0;
    localparam int unsigned RCR_BRK_BIT = 1;
    localparam int unsigned RCR_DEC_LSB = 2;
    localparam int unsigned RCR_VMEAS_BIT = 8;
    localparam int unsigned RCR_VEXT_BIT = 9;
    localparam int unsigned RCR_TF_BIT = 10;
    localparam int unsigned RCR_XBLK_BIT = 11;
    localparam logic [11:0] RCR_CTRL_RST = 12'h101;
    localparam logic [1:0] RCR_RESP_OKAY = 2'h0;
    localparam logic [1:0] RCR_RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {RCR_IDLE, RCR_EVAL, RCR_REL} rcr_state_t;
endpackage

`timescale 1ns/1ps
module rcr_channel (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Configuration
    input wire logic [11:0] ctrl,
    input wire logic [31:0] settle,
    // Filtered inputs
    input wire logic brk_closed,
    input wire logic [rcr_pkg::RCR_NDEC-1:0] decoup,
    input wire logic volt_ok,
    input wire logic freq_ok,
    input wire logic ext_volt_ok,
    input wire logic tf_fault,
    input wire logic ext_block,
    input wire logic other_eval,
    // Results
    output logic eval,
    output logic release_o
);
    import rcr_pkg::*;

    rcr_state_t state;
    logic [31:0] cnt;
    logic brk_prev;
    logic dec_prev;
    logic brk_asg;
    logic dec_asg;
    logic dec_any;
    logic rel_ok;
    logic all_ok;
    logic blocked;
    logic brk_fall;
    logic trig;
    logic drop;

    // Assignment decode and condition terms
    assign brk_asg = ctrl[RCR_BRK_BIT];
    assign dec_asg = |ctrl[RCR_DEC_LSB +: RCR_NDEC];
    assign dec_any = |(decoup & ctrl[RCR_DEC_LSB +: RCR_NDEC]); // [R17]
    assign rel_ok = freq_ok && (!ctrl[RCR_VMEAS_BIT] || volt_ok)
        && (!ctrl[RCR_VEXT_BIT] || ext_volt_ok); // [R11]
    assign all_ok = rel_ok && !dec_any;
    assign blocked = !ctrl[RCR_EN_BIT] || ext_block || (ctrl[RCR_TF_BIT] && tf_fault)
        || (ctrl[RCR_XBLK_BIT] && other_eval); // [R16] [R19]
    assign brk_fall = brk_prev && !brk_closed;

    // Trigger and release-drop per mode
    always_comb begin
        case ({brk_asg, dec_asg})
            2'b11: begin
                trig = brk_fall && dec_any; // [R1] [R13]
                drop = brk_closed || dec_any || !rel_ok; // [R4]
            end
            2'b10: begin
                trig = brk_fall; // [R5]
                drop = brk_closed || !rel_ok; // [R6]
            end
            2'b01: begin
                trig = dec_any && !dec_prev; // [R7]
                drop = dec_any || !rel_ok; // [R8]
            end
            default: begin
                trig = !rel_ok; // [R9]
                drop = !rel_ok; // [R10]
            end
        endcase
    end

    // Edge history
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            brk_prev <= 1'b0;
            dec_prev <= 1'b0;
        end else begin
            brk_prev <= brk_closed;
            dec_prev <= dec_any;
        end
    end

    // Trigger/evaluate/release sequence
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= RCR_IDLE; // [R20]
        end else if (blocked) begin
            state <= RCR_IDLE; // [R20]
        end else begin
            case (state)
                RCR_IDLE: begin
                    if (trig) begin
                        state <= RCR_EVAL; // [R2]
                    end
                end
                RCR_EVAL: begin
                    if (brk_asg && brk_closed) begin
                        state <= RCR_IDLE;
                    end else if (all_ok && cnt >= settle) begin
                        state <= RCR_REL; // [R3]
                    end
                end
                RCR_REL: begin
                    if (drop) begin
                        state <= trig ? RCR_EVAL : RCR_IDLE;
                    end
                end
                default: state <= RCR_IDLE;
            endcase
        end
    end

    // Settle timer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 32'h0000_0000;
        end else if (blocked || state != RCR_EVAL || !all_ok) begin
            cnt <= 32'h0000_0000; // [R18] [R20]
        end else if (cnt < settle) begin
            cnt <= cnt + 32'h0000_0001; // [R18]
        end
    end

    // Outputs straight from the state register
    assign eval = (state == RCR_EVAL); // [R2] [R21]
    assign release_o = (state == RCR_REL); // [R3] [R21]

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    exclusive_out_a: assert property (!(eval && release_o)) // [R21]
        else $error("evaluating and release both high");
    trig_both_a: assert property ((brk_asg && dec_asg && brk_fall && dec_any && !blocked
        && state == RCR_IDLE) |=> eval) // [R1]
        else $error("breaker fall with decoupling did not start evaluation");
    no_trig_a: assert property ((brk_asg && dec_asg && state == RCR_IDLE && !dec_any)
        |=> !eval) // [R1]
        else $error("evaluation started without decoupling");
    rel_cause_a: assert property ($rose(release_o) |-> $past(eval) && $past(all_ok)
        && $past(cnt) >= $past(settle)) // [R3]
        else $error("release without expired settle delay");
    rel_drop_a: assert property ((release_o && drop && !trig) |=> !release_o && !eval) // [R4]
        else $error("release not dropped");
    block_idle_a: assert property (blocked |=> !eval && !release_o && cnt == 32'h0) // [R16]
        else $error("block did not force idle");
    timer_restart_a: assert property ((eval && !all_ok) |=> cnt == 32'h0) // [R18]
        else $error("settle timer not restarted");
    timer_step_a: assert property ((eval && all_ok && cnt < settle && !blocked
        && !(brk_asg && brk_closed)) |=> cnt == $past(cnt) + 32'h1) // [R18]
        else $error("settle timer did not advance");
    unasg_trig_a: assert property ((!brk_asg && !dec_asg && !rel_ok && !blocked
        && !release_o) |=> eval) // [R9]
        else $error("failed conditions did not trigger");
endmodule // rcr_channel

//--- rcr_grid_model.sv
`timescale 1ns/1ps
module rcr_grid_model (
    // Clock
    input wire logic clk,
    // Bench commands
    input wire logic trip,
    input wire logic open_brk,
    input wire logic close_brk,
    input wire logic v_ok,
    input wire logic f_ok,
    input wire logic x_ok,
    // Pins toward the block
    output logic [1:0] brk_closed,
    output logic [5:0] decoup,
    output logic [1:0] volt_ok,
    output logic [1:0] freq_ok,
    output logic [1:0] ext_ok
);
    logic [4:0] step = 5'h0;

    // Trip sequence runs 31 cycles, further trips ignored meanwhile
    always_ff @(posedge clk) begin
        if (trip && step == 5'h0) begin
            step <= 5'h1;
        end else if (step != 5'h0) begin
            step <= step + 5'h1;
        end
    end

    // Breaker opens on command or six cycles into a trip
    always_ff @(posedge clk) begin
        if (close_brk) begin
            brk_closed <= 2'b11;
        end else if (open_brk || step == 5'h6) begin
            brk_closed <= 2'b00;
        end
    end

    // Trip rises first, holds over the opening, then falls back
    assign decoup = {5'h0, step != 5'h0 && step < 5'h11};
    assign volt_ok = {2{v_ok}};
    assign freq_ok = {2{f_ok}};
    assign ext_ok = {2{x_ok}};
endmodule // rcr_grid_model

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import rcr_pkg::*;
    logic MCLK = 1'b0;
    logic RSTN = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic trip = 1'b0, open_brk = 1'b0, close_brk = 1'b1;
    logic v_ok = 1'b1, f_ok = 1'b0, x_ok = 1'b1, tf = 1'b0;
    logic [1:0] xblk = 2'b00;
    logic [1:0] brk, vok, fok, xok, eval_o, rel_o, bresp, rresp;
    logic [5:0] dec;
    logic [31:0] rdata;
    logic awready, wready, bvalid, arready, rvalid;
    int fails = 0, cmp_count = 0, cyc = 0, n;

    // Clock at 200 MHz
    always #2.5 MCLK = ~MCLK;

    rcr_top #(.SETTLE_RESET(32'h8)) rcr_top_i (.MCLK(MCLK), .RSTN(RSTN),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .BRK_CLOSED_IN(brk), .DECOUP0_IN(dec), .DECOUP1_IN(dec),
        .VOLT_OK_IN(vok), .FREQ_OK_IN(fok), .EXTERNAL_VOLTAGE_OK_IN(xok),
        .TRANSFORMER_FAULT_IN(tf), .EXTERNAL_BLOCK_IN(xblk), .EVAL_OUT(eval_o),
        .RELEASE_OUT(rel_o));

    rcr_grid_model rcr_grid_model_i (.clk(MCLK), .trip(trip), .open_brk(open_brk),
        .close_brk(close_brk), .v_ok(v_ok), .f_ok(f_ok), .x_ok(x_ok), .brk_closed(brk),
        .decoup(dec), .volt_ok(vok), .freq_ok(fok), .ext_ok(xok));

    // Verdict and end of run
    task tally_and_finish;
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One AXI write, expected response given
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge MCLK);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge MCLK);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask

    // One AXI read, expected response and data given
    task rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
        @(posedge MCLK);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge MCLK);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk({30'h0, rresp}, {30'h0, er});
        chk(rdata, ed);
    endtask

    // Model command pulse: {close, open, trip}
    task act(input logic [2:0] k);
        @(posedge MCLK);
        {close_brk, open_brk, trip} <= k;
        @(posedge MCLK);
        {close_brk, open_brk, trip} <= 3'b000;
    endtask

    function automatic logic pin(input int i, input bit rel);
        return rel ? rel_o[i] : eval_o[i];
    endfunction

    // Wait a bounded time for an output level, then compare it
    task wt(input int i, input bit rel, input logic v, input int maxc);
        n = 0;
        while (pin(i, rel) !== v && n < maxc) begin
            @(posedge MCLK);
            n++;
        end
        chk({31'h0, pin(i, rel)}, {31'h0, v});
    endtask

    // Output must keep a level for a number of cycles
    task hold(input int i, input bit rel, input logic v, input int c);
        repeat (c) begin
            @(posedge MCLK);
            chk({31'h0, pin(i, rel)}, {31'h0, v});
        end
    endtask

    // Hang guard
    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            tally_and_finish;
        end
    end

    initial begin
        repeat (8) @(posedge MCLK);
        RSTN <= 1'b1;
        // Register reset values and refusals
        rd(RCR_CTRL0_OFS, RCR_RESP_OKAY, 32'h101);
        rd(RCR_SETTLE0_OFS, RCR_RESP_OKAY, 32'h8);
        rd(8'h14, RCR_RESP_SLVERR, 32'h0);
        wr(RCR_STATUS_OFS, 32'hf, RCR_RESP_SLVERR);
        $display("registers done");
        // Unassigned mode: frequency bad triggers, both instances
        wt(0, 0, 1'b1, 20);
        wt(1, 0, 1'b1, 20);
        f_ok <= 1'b1;
        wt(0, 1, 1'b1, 40);
        chk({31'h0, eval_o[0]}, 32'h0);
        rd(RCR_STATUS_OFS, RCR_RESP_OKAY, 32'hc);
        f_ok <= 1'b0;
        wt(0, 1, 1'b0, 10);
        wt(0, 0, 1'b1, 5);
        f_ok <= 1'b1;
        wt(0, 1, 1'b1, 40);
        wr(RCR_CTRL0_OFS, 32'h301, RCR_RESP_OKAY);
        x_ok <= 1'b0;
        wt(0, 1, 1'b0, 10);
        x_ok <= 1'b1;
        $display("unassigned done");
        // Breaker only: opening triggers, settle timing, closing drops
        wr(RCR_CTRL0_OFS, 32'h103, RCR_RESP_OKAY);
        wt(0, 1, 1'b0, 10);
        act(3'b010);
        wt(0, 0, 1'b1, 10);
        wt(0, 1, 1'b1, 20);
        chk(n, 9);
        act(3'b100);
        wt(0, 1, 1'b0, 10);
        $display("breaker only done");
        // Breaker and trip: opening without trip is ignored
        wr(RCR_CTRL0_OFS, 32'h107, RCR_RESP_OKAY);
        act(3'b010);
        hold(0, 0, 1'b0, 20);
        act(3'b100);
        repeat (10) @(posedge MCLK);
        act(3'b001);
        wt(0, 0, 1'b1, 20);
        hold(0, 1, 1'b0, 8);
        wt(0, 1, 1'b1, 60);
        act(3'b001);
        wt(0, 1, 1'b0, 15);
        repeat (40) @(posedge MCLK);
        $display("breaker and trip done");
        // Trip only: trip rising edge triggers and drops release
        wr(RCR_CTRL0_OFS, 32'h105, RCR_RESP_OKAY);
        act(3'b001);
        wt(0, 0, 1'b1, 15);
        wt(0, 1, 1'b1, 60);
        act(3'b001);
        wt(0, 1, 1'b0, 15);
        xblk <= 2'b01;
        wt(0, 0, 1'b0, 10);
        hold(0, 1, 1'b0, 40);
        xblk <= 2'b00;
        $display("trip only done");
        // Disabled, then transformer fault in use
        f_ok <= 1'b0;
        wr(RCR_CTRL0_OFS, 32'h100, RCR_RESP_OKAY);
        hold(0, 0, 1'b0, 20);
        f_ok <= 1'b1;
        wr(RCR_CTRL0_OFS, 32'h501, RCR_RESP_OKAY);
        f_ok <= 1'b0;
        wt(0, 0, 1'b1, 20);
        f_ok <= 1'b1;
        wt(0, 1, 1'b1, 40);
        tf <= 1'b1;
        wt(0, 1, 1'b0, 10);
        f_ok <= 1'b0;
        hold(0, 0, 1'b0, 20);
        $display("blocking done");
        // Second instance held off while the first one evaluates
        tf <= 1'b0;
        wr(RCR_SETTLE1_OFS, 32'h10, RCR_RESP_OKAY);
        wr(RCR_CTRL1_OFS, 32'h901, RCR_RESP_OKAY);
        wr(RCR_CTRL0_OFS, 32'h101, RCR_RESP_OKAY);
        hold(1, 0, 1'b0, 10);
        f_ok <= 1'b1;
        wt(0, 1, 1'b1, 40);
        hold(1, 1, 1'b0, 30);
        rd(RCR_SETTLE1_OFS, RCR_RESP_OKAY, 32'h10);
        $display("second instance done");
        tally_and_finish;
    end
endmodule // tb_top
